// file: core/cat_pkg.sv
// Purpose: Shared constants for the counter array time base
// Assumes: mclk is the oscillator clock of the counter array
// Notes: Register indices times four give the Avalon byte address
package cat_pkg;
  // Avalon byte address width
  localparam int ADDR_W = 10;
  // Register indices
  localparam logic [7:0] IDX_MODE = 8'hD9;
  localparam logic [7:0] IDX_CTRL = 8'hD8;
  localparam logic [7:0] IDX_CNT_LO = 8'h00;
  localparam logic [7:0] IDX_CNT_HI = 8'h01;
  localparam logic [7:0] IDX_AUX = 8'h02;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h03;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h04;
  // Mode register fields
  localparam int MODE_IDLE_GATE = 7;
  localparam int MODE_WDT_EN = 6;
  localparam int MODE_SEL_HI = 2;
  localparam int MODE_SEL_LO = 1;
  localparam int MODE_OVF_IE = 0;
  // Control register fields
  localparam int CTRL_OVF = 7;
  localparam int CTRL_RUN = 6;
  localparam int NUM_MODULES = 5;
  // Auxiliary register fields
  localparam int AUX_DOUBLE_SPEED = 0;
  // Interrupt status layout
  localparam int IRQ_W = 6;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_MOD_LO = 1;
  // Reset values and counter wrap value
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ALL_ONES = 16'hFFFF;
  // Oscillator cycles per count event
  localparam logic [3:0] PRE_STD_SLOW = 4'hC;
  localparam logic [3:0] PRE_X2_SLOW = 4'h6;
  localparam logic [3:0] PRE_STD_FAST = 4'h4;
  localparam logic [3:0] PRE_X2_FAST = 4'h2;

  typedef enum logic [1:0] {
    SRC_OSC_SLOW,
    SRC_OSC_FAST,
    SRC_TIMER0,
    SRC_EXT_PIN
  } cat_src_type;
endpackage

// file: core/cat_rate_gen.sv
// Purpose: Count-event source for the counter array time base
// Assumes: timer0_overflow is a one-cycle pulse on mclk
// Notes: External pin counts falling edges after a two-stage sync
`timescale 1ns/100ps
module cat_rate_gen #(
  parameter int PRE_W = 4
) (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Source control
  input wire logic [1:0] count_select,
  input wire logic double_speed,
  // Event inputs
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  // Selected count event
  output logic count_tick
);
  cat_pkg::cat_src_type src;
  logic [PRE_W-1:0] pre_r;
  logic [PRE_W-1:0] div;
  logic pre_hit;
  logic sync1_r;
  logic sync2_r;
  logic sync3_r;
  logic ext_fall;
  logic tick_r;

  assign src = cat_pkg::cat_src_type'(count_select);

  always_comb begin
    if (src == cat_pkg::SRC_OSC_SLOW) begin
      div = double_speed ? cat_pkg::PRE_X2_SLOW : cat_pkg::PRE_STD_SLOW; // R3 R14
    end else begin
      div = double_speed ? cat_pkg::PRE_X2_FAST : cat_pkg::PRE_STD_FAST; // R3 R14
    end
  end

  // Compare with >= so a select change never strands the count
  assign pre_hit = (pre_r >= div - 4'h1);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else if (clk_en) begin
      pre_r <= pre_hit ? '0 : pre_r + 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      sync3_r <= 1'b1;
    end else if (clk_en) begin
      sync1_r <= external_count_input;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  assign ext_fall = sync3_r & ~sync2_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      tick_r <= 1'b0;
    end else if (clk_en) begin
      case (src)
        cat_pkg::SRC_OSC_SLOW: tick_r <= pre_hit; // R3
        cat_pkg::SRC_OSC_FAST: tick_r <= pre_hit; // R3
        cat_pkg::SRC_TIMER0: tick_r <= timer0_overflow; // R3
        default: tick_r <= ext_fall; // R3
      endcase
    end
  end

  assign count_tick = tick_r & clk_en;

  a_timer0_tick: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    clk_en && src == cat_pkg::SRC_TIMER0 && timer0_overflow
    |=> tick_r)
    else $error("timer 0 overflow did not give a count event");

  a_ext_tick: assert property (@(posedge mclk) disable iff (!rst_n) // R3
    clk_en && src == cat_pkg::SRC_EXT_PIN && ext_fall
    |=> tick_r)
    else $error("pin edge did not give a count event");
endmodule

// file: core/cat_timebase.sv
// Purpose: Shared 16-bit time base of a programmable counter array
// Assumes: Avalon-MM slave on mclk, all event inputs on mclk
// Notes: One wait state per access; reserved bits read as zero
// Notes on behaviour
// R1 - 16-bit counter counts events, wraps as overflow
// R2 - Counter advances only while run bit set
// R3 - Two select bits pick the count source
// R4 - Idle gate bit stops counting during idle
// R5 - Watchdog on module 4 follows enable bit
// R6 - Counter wrap sets the overflow flag
// R7 - Overflow requests interrupt only when enabled
// R8 - Only a software zero write clears overflow
// R9 - Software writing one sets overflow flag
// R10 - Module match or capture sets its flag
// R11 - Only software zero write clears module flags
// R12 - Mode register fields reset to zero
// R13 - Software writes zero to reserved bits
// R14 - Double speed halves internal source periods
`timescale 1ns/100ps
module cat_timebase (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire logic [cat_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Count sources and system state
  input wire logic timer0_overflow,
  input wire logic external_count_input,
  input wire logic cpu_idle,
  // Compare and capture modules
  input wire logic [cat_pkg::NUM_MODULES-1:0] module_event,
  output logic [15:0] counter_value,
  output logic counter_advance,
  output logic watchdog_enable_m4,
  // Interrupts
  output logic overflow_irq_req,
  output logic irq
);
  logic [7:0] mode_r;
  logic overflow_flag_r;
  logic run_control_r;
  logic [cat_pkg::NUM_MODULES-1:0] mflag_r;
  logic [15:0] cnt_r;
  logic double_speed_r;
  logic [cat_pkg::IRQ_W-1:0] ist_r;
  logic [cat_pkg::IRQ_W-1:0] imsk_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rd_val;
  logic sel_mode;
  logic sel_ctrl;
  logic sel_lo;
  logic sel_hi;
  logic sel_aux;
  logic sel_ist;
  logic sel_imsk;
  logic wr_go;
  logic [7:0] wd;
  logic tick;
  logic advance;
  logic cnt_wr;
  logic wrap;
  logic [cat_pkg::IRQ_W-1:0] irq_ev;

  // Address decode, byte address is four times the index
  always_comb begin
    sel_mode = 1'b0;
    sel_ctrl = 1'b0;
    sel_lo = 1'b0;
    sel_hi = 1'b0;
    sel_aux = 1'b0;
    sel_ist = 1'b0;
    sel_imsk = 1'b0;
    if (avs_address == {cat_pkg::IDX_MODE, 2'b00}) begin
      sel_mode = 1'b1;
    end else if (avs_address == {cat_pkg::IDX_CTRL, 2'b00}) begin
      sel_ctrl = 1'b1;
    end else if (avs_address == {cat_pkg::IDX_CNT_LO, 2'b00}) begin
      sel_lo = 1'b1;
    end else if (avs_address == {cat_pkg::IDX_CNT_HI, 2'b00}) begin
      sel_hi = 1'b1;
    end else if (avs_address == {cat_pkg::IDX_AUX, 2'b00}) begin
      sel_aux = 1'b1;
    end else if (avs_address == {cat_pkg::IDX_IRQ_STAT, 2'b00}) begin
      sel_ist = 1'b1;
    end else if (avs_address == {cat_pkg::IDX_IRQ_MASK, 2'b00}) begin
      sel_imsk = 1'b1;
    end
  end

  // Fixed single wait state keeps read data registered
  // Held off while frozen, else a write would be lost
  assign avs_waitrequest = (avs_read | avs_write) & ~(ack_r & clk_en);
  assign wr_go = avs_write & ack_r & clk_en & avs_byteenable[0];
  assign wd = avs_writedata[7:0];
  assign avs_readdata = rdata_r;

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else if (clk_en) begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    if (sel_mode) begin
      // Reserved bits 5..3 read as zero
      rd_val[7:0] = {mode_r[7:6], 3'b000, mode_r[2:0]};
    end else if (sel_ctrl) begin
      rd_val[7:0] = {overflow_flag_r, run_control_r, 1'b0, mflag_r};
    end else if (sel_lo) begin
      rd_val[7:0] = cnt_r[7:0];
    end else if (sel_hi) begin
      rd_val[7:0] = cnt_r[15:8];
    end else if (sel_aux) begin
      rd_val[cat_pkg::AUX_DOUBLE_SPEED] = double_speed_r;
    end else if (sel_ist) begin
      rd_val[cat_pkg::IRQ_W-1:0] = ist_r;
    end else if (sel_imsk) begin
      rd_val[cat_pkg::IRQ_W-1:0] = imsk_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata_r <= 32'h00000000;
    end else if (clk_en && avs_read && !ack_r) begin
      rdata_r <= rd_val;
    end
  end

  // Mode register, reserved bits kept at zero
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_r <= cat_pkg::MODE_RST; // R12
    end else if (wr_go && sel_mode) begin
      mode_r <= {wd[7:6], 3'b000, wd[2:0]};
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      double_speed_r <= 1'b0;
    end else if (wr_go && sel_aux) begin
      double_speed_r <= wd[cat_pkg::AUX_DOUBLE_SPEED];
    end
  end

  cat_rate_gen #(
    .PRE_W(4)
  ) u_rate (
    .mclk(mclk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .count_select(mode_r[cat_pkg::MODE_SEL_HI:cat_pkg::MODE_SEL_LO]),
    .double_speed(double_speed_r),
    .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input),
    .count_tick(tick)
  );

  assign advance = tick & run_control_r // R2
    & ~(mode_r[cat_pkg::MODE_IDLE_GATE] & cpu_idle); // R4
  assign cnt_wr = wr_go & (sel_lo | sel_hi);
  assign wrap = advance & ~cnt_wr & (cnt_r == cat_pkg::CNT_ALL_ONES); // R1

  // Software byte write wins over a count in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_r <= cat_pkg::CNT_RST;
    end else if (wr_go && sel_lo) begin
      cnt_r <= {cnt_r[15:8], wd};
    end else if (wr_go && sel_hi) begin
      cnt_r <= {wd, cnt_r[7:0]};
    end else if (advance) begin
      cnt_r <= cnt_r + 16'h0001; // R1
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      run_control_r <= 1'b0;
    end else if (wr_go && sel_ctrl) begin
      run_control_r <= wd[cat_pkg::CTRL_RUN]; // R2
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      overflow_flag_r <= 1'b0;
    end else if (wrap) begin
      overflow_flag_r <= 1'b1; // R6
    end else if (wr_go && sel_ctrl) begin
      overflow_flag_r <= wd[cat_pkg::CTRL_OVF]; // R8 R9
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mflag_r <= '0;
    end else if (clk_en) begin
      if (wr_go && sel_ctrl) begin
        mflag_r <= wd[cat_pkg::NUM_MODULES-1:0] | module_event; // R10 R11
      end else begin
        mflag_r <= mflag_r | module_event; // R10 R11
      end
    end
  end

  // Sticky status, write one to clear, new event wins
  assign irq_ev = {module_event & {cat_pkg::NUM_MODULES{clk_en}}, wrap};

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ist_r <= '0;
    end else if (wr_go && sel_ist) begin
      ist_r <= (ist_r & ~wd[cat_pkg::IRQ_W-1:0]) | irq_ev;
    end else begin
      ist_r <= ist_r | irq_ev;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      imsk_r <= '0;
    end else if (wr_go && sel_imsk) begin
      imsk_r <= wd[cat_pkg::IRQ_W-1:0];
    end
  end

  assign irq = |(ist_r & imsk_r);
  assign overflow_irq_req = overflow_flag_r
    & mode_r[cat_pkg::MODE_OVF_IE]; // R7
  assign watchdog_enable_m4 = mode_r[cat_pkg::MODE_WDT_EN]; // R5
  assign counter_value = cnt_r;
  assign counter_advance = advance;

  // Local checks of counter, flags and bus handshake
  a_count_step: assert property ( // R1
    @(posedge mclk) disable iff (!rst_n)
    advance && !cnt_wr |=> cnt_r == $past(cnt_r) + 16'h0001)
    else $error("counter did not step by one");

  a_freeze_count: assert property ( // R1
    @(posedge mclk) disable iff (!rst_n)
    !clk_en |=> cnt_r == $past(cnt_r))
    else $error("counter moved while the clock enable was low");

  a_run_hold: assert property ( // R2
    @(posedge mclk) disable iff (!rst_n)
    !run_control_r && !cnt_wr |=> cnt_r == $past(cnt_r))
    else $error("counter moved while stopped");

  a_run_sw_only: assert property ( // R2
    @(posedge mclk) disable iff (!rst_n)
    !(wr_go && sel_ctrl) |=> run_control_r == $past(run_control_r))
    else $error("run bit changed without a control write");

  a_idle_gate: assert property ( // R4
    @(posedge mclk) disable iff (!rst_n)
    mode_r[cat_pkg::MODE_IDLE_GATE] && cpu_idle && !cnt_wr
    |=> cnt_r == $past(cnt_r))
    else $error("counter moved while gated in idle");

  a_wdt_enable: assert property ( // R5
    @(posedge mclk) disable iff (!rst_n)
    wr_go && sel_mode
    |=> watchdog_enable_m4 == $past(wd[cat_pkg::MODE_WDT_EN]))
    else $error("watchdog enable does not follow mode write");

  a_mode_hold: assert property ( // R5
    @(posedge mclk) disable iff (!rst_n)
    !(wr_go && sel_mode) |=> mode_r == $past(mode_r))
    else $error("mode register changed without a write");

  a_ovf_set: assert property ( // R6
    @(posedge mclk) disable iff (!rst_n)
    advance && !cnt_wr && cnt_r == cat_pkg::CNT_ALL_ONES
    |=> overflow_flag_r && cnt_r == cat_pkg::CNT_RST)
    else $error("wrap did not set overflow flag");

  a_ovf_status: assert property ( // R6
    @(posedge mclk) disable iff (!rst_n)
    wrap |=> ist_r[cat_pkg::IRQ_OVF])
    else $error("wrap did not set its status bit");

  a_ovf_irq_gate: assert property ( // R7
    @(posedge mclk) disable iff (!rst_n)
    !mode_r[cat_pkg::MODE_OVF_IE] |-> !overflow_irq_req)
    else $error("overflow request while disabled");

  a_ovf_sticky: assert property ( // R8
    @(posedge mclk) disable iff (!rst_n)
    overflow_flag_r && !(wr_go && sel_ctrl) |=> overflow_flag_r)
    else $error("overflow flag cleared by hardware");

  a_ovf_sw_set: assert property ( // R9
    @(posedge mclk) disable iff (!rst_n)
    wr_go && sel_ctrl && wd[cat_pkg::CTRL_OVF] |=> overflow_flag_r)
    else $error("software set of overflow flag lost");

  a_mod_set: assert property ( // R10
    @(posedge mclk) disable iff (!rst_n)
    clk_en && module_event != '0
    |=> (mflag_r & $past(module_event)) == $past(module_event))
    else $error("module event did not set its flag");

  a_mod_sticky: assert property ( // R11
    @(posedge mclk) disable iff (!rst_n)
    !(wr_go && sel_ctrl) |=> (mflag_r & $past(mflag_r)) == $past(mflag_r))
    else $error("module flag cleared by hardware");

  a_flag_freeze: assert property ( // R6 R10
    @(posedge mclk) disable iff (!rst_n)
    !clk_en |=> overflow_flag_r == $past(overflow_flag_r)
      && mflag_r == $past(mflag_r))
    else $error("flags changed while the clock enable was low");

  a_stat_sticky: assert property (
    @(posedge mclk) disable iff (!rst_n)
    !(wr_go && sel_ist) |=> (ist_r & $past(ist_r)) == $past(ist_r))
    else $error("status bit cleared without a write");

  a_bus_first: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (avs_read || avs_write) && !ack_r |-> avs_waitrequest)
    else $error("bus answered in the cycle of the request");

  a_bus_frozen: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (avs_read || avs_write) && !clk_en |-> avs_waitrequest)
    else $error("bus answered while the clock enable was low");

  a_bus_answer: assert property (
    @(posedge mclk) disable iff (!rst_n)
    (avs_read || avs_write) && !ack_r && clk_en
    ##1 (avs_read || avs_write) && clk_en |-> !avs_waitrequest)
    else $error("bus did not answer one cycle after the request");
endmodule

// file: test/cat_timebase_bench.sv
// Purpose: Self-checking bench for the counter array time base
// Assumes: One wait state per access, counter_advance pulses once a tick
// Notes: Rate windows span 48 cycles, a whole number of every period
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  n_fail++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module cat_timebase_bench;
  localparam logic [9:0] A_MODE = {cat_pkg::IDX_MODE, 2'b00};
  localparam logic [9:0] A_CTRL = {cat_pkg::IDX_CTRL, 2'b00};
  localparam logic [9:0] A_LO = {cat_pkg::IDX_CNT_LO, 2'b00};
  localparam logic [9:0] A_HI = {cat_pkg::IDX_CNT_HI, 2'b00};
  localparam logic [9:0] A_AUX = {cat_pkg::IDX_AUX, 2'b00};
  localparam logic [9:0] A_STAT = {cat_pkg::IDX_IRQ_STAT, 2'b00};
  localparam logic [9:0] A_MASK = {cat_pkg::IDX_IRQ_MASK, 2'b00};
  logic mclk;
  logic rst_n;
  logic clk_en;
  logic [cat_pkg::ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic timer0_overflow;
  logic external_count_input;
  logic cpu_idle;
  logic [cat_pkg::NUM_MODULES-1:0] module_event;
  logic [15:0] counter_value;
  logic counter_advance;
  logic watchdog_enable_m4;
  logic overflow_irq_req;
  logic irq;
  logic [7:0] rd;
  int n_fail = 0;
  int compares = 0;
  int adv_cnt = 0;

  cat_timebase dut (
    .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input),
    .cpu_idle(cpu_idle), .module_event(module_event),
    .counter_value(counter_value), .counter_advance(counter_advance),
    .watchdog_enable_m4(watchdog_enable_m4),
    .overflow_irq_req(overflow_irq_req), .irq(irq)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // Non-blocking so readers at the same edge see a settled count
  always @(posedge mclk) begin
    if (counter_advance === 1'b1) adv_cnt <= adv_cnt + 1;
  end

  task test_done;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task waitc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task endt(input string nm);
    $display("test %s done", nm);
  endtask

  // Request held until the edge where waitrequest is seen low
  task bus(input logic wr_en, input logic [9:0] a, input logic [7:0] d);
    int i;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr_en;
    avs_read <= ~wr_en;
    avs_writedata <= {24'h000000, d};
    i = 0;
    do begin
      @(posedge mclk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_fail++;
      $display("mismatch waitrequest exp 0 got %b", avs_waitrequest);
      test_done();
    end
  endtask

  task wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  task rdchk(input string nm, input logic [9:0] a, input logic [7:0] ex);
    bus(1'b0, a, 8'h00);
    `CHK(nm, ex, rd)
  endtask

  task tick_chk(input string nm, input int ex);
    int s;
    waitc(24);
    s = adv_cnt;
    waitc(48);
    `CHK(nm, ex, adv_cnt - s)
  endtask

  initial begin
    logic [3:0] per [4];
    int s;
    logic [15:0] held;
    per = '{cat_pkg::PRE_STD_SLOW, cat_pkg::PRE_STD_FAST,
            cat_pkg::PRE_X2_SLOW, cat_pkg::PRE_X2_FAST};
    rst_n = 1'b0;
    clk_en = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    timer0_overflow = 1'b0;
    external_count_input = 1'b1;
    cpu_idle = 1'b0;
    module_event = '0;
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk("mode reset", A_MODE, 8'h00);
    `CHK("wdt reset", 1'b0, watchdog_enable_m4)
    rdchk("unmapped", 10'h3FC, 8'h00);
    wr(A_MODE, 8'hC7);
    rdchk("mode rw", A_MODE, 8'hC7);
    `CHK("wdt on", 1'b1, watchdog_enable_m4)
    avs_byteenable <= 4'h0;
    wr(A_MODE, 8'h00);
    avs_byteenable <= 4'hF;
    rdchk("mode be0", A_MODE, 8'hC7);
    wr(A_MODE, 8'h00);
    waitc(1);
    `CHK("wdt off", 1'b0, watchdog_enable_m4)
    endt("mode");
    wr(A_LO, 8'h34);
    wr(A_HI, 8'h12);
    waitc(1);
    `CHK("counter", 16'h1234, counter_value)
    rdchk("cnt lo", A_LO, 8'h34);
    rdchk("cnt hi", A_HI, 8'h12);
    endt("counter bytes");
    wr(A_CTRL, 8'h40);
    for (int k = 0; k < 4; k++) begin
      wr(A_AUX, {7'h00, k[1]});
      wr(A_MODE, {5'h00, 1'b0, k[0], 1'b0});
      tick_chk("rate", 48 / int'(per[k]));
    end
    endt("rates");
    cpu_idle <= 1'b1;
    wr(A_AUX, 8'h00);
    wr(A_MODE, 8'h02);
    tick_chk("idle run", 12);
    wr(A_MODE, 8'h82);
    tick_chk("idle gated", 0);
    cpu_idle <= 1'b0;
    tick_chk("awake", 12);
    wr(A_CTRL, 8'h00);
    tick_chk("stopped", 0);
    endt("idle and run");
    wr(A_MODE, 8'h04);
    wr(A_CTRL, 8'h40);
    s = adv_cnt;
    repeat (5) begin
      timer0_overflow <= 1'b1;
      @(posedge mclk);
      timer0_overflow <= 1'b0;
      waitc(3);
    end
    waitc(4);
    `CHK("timer0", 5, adv_cnt - s)
    wr(A_MODE, 8'h06);
    s = adv_cnt;
    repeat (3) begin
      external_count_input <= 1'b0;
      waitc(10);
      external_count_input <= 1'b1;
      waitc(10);
    end
    `CHK("pin", 3, adv_cnt - s)
    endt("event sources");
    wr(A_CTRL, 8'h00);
    wr(A_MODE, 8'h02);
    wr(A_LO, 8'hFF);
    wr(A_HI, 8'hFF);
    wr(A_CTRL, 8'h40);
    waitc(20);
    `CHK("req off", 1'b0, overflow_irq_req)
    rdchk("ovf set", A_CTRL, 8'hC0);
    wr(A_CTRL, 8'h80);
    waitc(30);
    rdchk("ovf sticky", A_CTRL, 8'h80);
    rdchk("stat ovf", A_STAT, 8'h01);
    `CHK("irq masked", 1'b0, irq)
    wr(A_MASK, 8'h01);
    waitc(1);
    `CHK("irq on", 1'b1, irq)
    wr(A_STAT, 8'h01);
    waitc(1);
    `CHK("irq w1c", 1'b0, irq)
    wr(A_MODE, 8'h03);
    waitc(1);
    `CHK("req on", 1'b1, overflow_irq_req)
    wr(A_CTRL, 8'h00);
    waitc(1);
    `CHK("req clr", 1'b0, overflow_irq_req)
    wr(A_CTRL, 8'h80);
    waitc(1);
    `CHK("req sw set", 1'b1, overflow_irq_req)
    rdchk("ovf sw set", A_CTRL, 8'h80);
    endt("overflow");
    wr(A_CTRL, 8'h00);
    wr(A_MASK, 8'h3E);
    for (int n = 0; n < cat_pkg::NUM_MODULES; n++) begin
      module_event <= 5'h01 << n;
      @(posedge mclk);
      module_event <= '0;
      waitc(20);
      rdchk("mod flag", A_CTRL, 8'h01 << n);
      `CHK("mod irq", 1'b1, irq)
      wr(A_STAT, 8'h02 << n);
      wr(A_CTRL, 8'h00);
      waitc(1);
      `CHK("mod irq clr", 1'b0, irq)
      rdchk("mod clr", A_CTRL, 8'h00);
    end
    endt("module flags");
    // Enable drops mid-access: the write must wait, not vanish
    fork
      wr(A_LO, 8'h5A);
      begin
        waitc(2);
        clk_en <= 1'b0;
        waitc(5);
        clk_en <= 1'b1;
      end
    join
    rdchk("frozen write", A_LO, 8'h5A);
    wr(A_CTRL, 8'h40);
    clk_en <= 1'b0;
    waitc(1);
    s = adv_cnt;
    held = counter_value;
    waitc(20);
    `CHK("frozen ticks", 0, adv_cnt - s)
    `CHK("frozen count", held, counter_value)
    clk_en <= 1'b1;
    tick_chk("thawed", 12);
    wr(A_CTRL, 8'h00);
    endt("clock enable");
    test_done();
  end
endmodule
